// ===== common/vpic_pkg.sv
// Functional notes
// - Concurrent mode: all maskable vectors run at level 3
// - Concurrent rank: main, IT4..IT0, trap, reset highest
// - Any field below level 3 selects nested mode
// - Nested rank breaks ties between equal software levels
// - Field codes: 10=L0, 01=L1, 00=L2, 11=L3
// - Writing 10 to a field keeps old value
// - Reset and trap set current level to 3
// - Raised priority while running re-enters pending vector
// - Halt, pop, enable, disable, wait change current level
// - Field pair n belongs to vector n, 0..29
// - Eleven external vectors: three port groups, eight bits
// - Pin interrupts only when input with enable set
// - Event sets pending flag; writing 1 clears it
// - Enable instruction loads level code 10
// - Disable instruction loads level code 11
// - Return pops flags, restoring saved level bits
// - Masked branch when level is 11, else unmasked
// - Acceptance loads level from vector field; reset 0x28
// - Last priority register upper nibble reads ones
// - Nesting depth unchecked, no overflow flag
// - Highest software level first, ties by rank, rest latched
// - Pins sharing one vector are ORed
// - Sensitivity: 00 fall+low, 01 rise, 10 fall, 11 both
// - Sensitivity writes only at current level 3
package vpic_pkg;
    localparam int NUM_VEC = 30;
    localparam int NUM_PRIO_REGS = 8;
    localparam int NUM_PORTS = 8;
    localparam int NUM_PINS = 64;
    localparam int ADDR_BITS = 8;

    // Priority register indices; byte address is index times four
    localparam logic [7:0] PRIO_IDX_FIRST = 8'h00;
    localparam logic [7:0] PRIO_IDX_LAST = 8'h07;
    localparam logic [7:0] ADDR_SENS_BIT_LO = 8'h20;
    localparam logic [7:0] ADDR_SENS_BIT_HI = 8'h24;
    localparam logic [7:0] ADDR_SENS_PORT_LO = 8'h28;
    localparam logic [7:0] ADDR_SENS_PORT_HI = 8'h2C;
    localparam logic [7:0] ADDR_PEND_BITS = 8'h30;
    localparam logic [7:0] ADDR_PEND_GROUPS = 8'h34;
    localparam logic [7:0] ADDR_GROUP_SEL = 8'h38;
    localparam logic [7:0] ADDR_FLAGS = 8'h3C;
    localparam logic [7:0] ADDR_STATUS = 8'h40;

    localparam logic [7:0] PRIO_RESET = 8'hFF;
    localparam logic [7:0] PRIO_LAST_FORCED = 8'hF0;
    localparam logic [7:0] FLAGS_RESET = 8'h28;
    localparam logic [7:0] SENS_RESET = 8'h00;
    localparam logic [3:0] SENS_HI_RESET = 4'h0;
    localparam logic [7:0] PEND_RESET = 8'h00;
    localparam logic [2:0] PEND_GRP_RESET = 3'h0;
    localparam logic [5:0] GROUP_SEL_RESET = 6'h00;

    localparam int FLAG_LVL_HI_POS = 5;
    localparam int FLAG_LVL_LO_POS = 3;

    localparam logic [1:0] LVL0 = 2'b10;
    localparam logic [1:0] LVL1 = 2'b01;
    localparam logic [1:0] LVL2 = 2'b00;
    localparam logic [1:0] LVL3 = 2'b11;

    localparam logic [1:0] SENS_FALL_LOW = 2'b00;
    localparam logic [1:0] SENS_RISE = 2'b01;
    localparam logic [1:0] SENS_FALL = 2'b10;
    localparam logic [1:0] SENS_BOTH = 2'b11;

    // Ports A..H are 0..7
    localparam int PORT_B = 1;
    localparam int PORT_D = 3;
    localparam int PORT_E = 4;
    localparam int PORT_F = 5;
    localparam int PORT_G = 6;
    localparam int PORT_H = 7;

    localparam logic [4:0] VEC_GROUP_A = 5'h05;
    localparam logic [4:0] VEC_GROUP_B = 5'h06;
    localparam logic [4:0] VEC_GROUP_C = 5'h07;
    localparam int VEC_BIT0 = 8;

    typedef struct packed {
        logic enable_irq_instr;
        logic disable_irq_instr;
        logic halt_instr;
        logic wait_irq_instr;
        logic wait_event_instr;
        logic flags_pop_instr;
        logic handler_return_instr;
        logic trap_instr;
        logic irq_ack;
        logic [7:0] pop_data;
    } vpic_cpu_op_type;

    typedef struct packed {
        logic [63:0] level;
        logic [63:0] is_input;
        logic [63:0] irq_en;
    } vpic_pins_type;
endpackage

// ===== rtl/vpic_ctrl.sv
`timescale 1ns/1ps
module vpic_ctrl (
    input wire logic mclk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire vpic_pkg::vpic_cpu_op_type cpu_op,
    input wire logic [29:0] periph_irq,
    input wire vpic_pkg::vpic_pins_type pins,
    output logic irq_valid,
    output logic [4:0] irq_vector,
    output logic [7:0] condition_code_flags,
    output logic branch_if_masked,
    output logic branch_if_unmasked,
    output logic nested_mode
);
    logic dp_valid_q;
    logic dp_write_q;
    logic [7:0] dp_addr_q;
    logic rd_done_q;
    logic [31:0] hrdata_q;
    logic [7:0] prio_q [vpic_pkg::NUM_PRIO_REGS];
    logic [7:0] flags_q;
    logic [7:0] sens_lo_q;
    logic [7:0] sens_hi_q;
    logic [7:0] sens_port_q;
    logic [3:0] sens_port_hi_q;
    logic [5:0] group_sel_q;
    logic [7:0] pend_bits_q;
    logic [2:0] pend_grp_q;
    logic [63:0] pin_meta_q;
    logic [63:0] pin_sync_q;
    logic [63:0] pin_prev_q;
    logic irq_valid_q;
    logic [4:0] irq_vector_q;
    logic [1:0] irq_code_q;
    logic wr_en;
    logic [1:0] cur_code;
    logic [7:0] bit_event;
    logic [2:0] grp_event;
    logic [29:0] vec_req;
    logic win_found;
    logic [4:0] win_vec;
    logic [1:0] win_code;
    logic level_change;
    logic [31:0] rd_mux;
    logic [1:0] vec_code [vpic_pkg::NUM_VEC];

    // Level code to rank, 0 lowest
    function automatic logic [1:0] code_rank(input logic [1:0] code);
        logic [1:0] r;
        r = 2'd0;
        unique case (code)
            vpic_pkg::LVL0: r = 2'd0;
            vpic_pkg::LVL1: r = 2'd1;
            vpic_pkg::LVL2: r = 2'd2;
            vpic_pkg::LVL3: r = 2'd3;
        endcase
        return r;
    endfunction

    function automatic logic pin_event(input logic [1:0] sens, input logic cur, input logic prev);
        logic rise;
        logic fall;
        logic e;
        rise = cur & ~prev;
        fall = ~cur & prev;
        e = 1'b0;
        unique case (sens)
            vpic_pkg::SENS_FALL_LOW: e = fall | ~cur;
            vpic_pkg::SENS_RISE: e = rise;
            vpic_pkg::SENS_FALL: e = fall;
            vpic_pkg::SENS_BOTH: e = rise | fall;
        endcase
        return e;
    endfunction

    // Write-ignoring of level-0 code per field
    function automatic logic [7:0] prio_merge(input logic [7:0] old, input logic [7:0] wd);
        logic [7:0] r;
        r = old;
        for (int f = 0; f < 4; f++) begin
            if (wd[2*f +: 2] != vpic_pkg::LVL0) begin
                r[2*f +: 2] = wd[2*f +: 2];
            end
        end
        return r;
    endfunction

    assign cur_code = {flags_q[vpic_pkg::FLAG_LVL_HI_POS], flags_q[vpic_pkg::FLAG_LVL_LO_POS]};

    // AHB-Lite slave: writes zero-wait, reads take one wait state
    assign hresp = 1'b0;
    assign hreadyout = ~(dp_valid_q & ~dp_write_q & ~rd_done_q);
    assign hrdata = hrdata_q;
    assign wr_en = dp_valid_q & dp_write_q;

    always_ff @(posedge mclk) begin
        if (reset) begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q <= 8'h00;
        end else if (hready) begin
            dp_valid_q <= hsel & htrans[1];
            dp_write_q <= hwrite;
            dp_addr_q <= haddr[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rd_done_q <= 1'b0;
            hrdata_q <= 32'h0000_0000;
        end else begin
            rd_done_q <= dp_valid_q & ~dp_write_q & ~rd_done_q;
            if (dp_valid_q & ~dp_write_q & ~rd_done_q) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (dp_addr_q[1:0] == 2'b00 && dp_addr_q[7:2] <= vpic_pkg::PRIO_IDX_LAST[5:0]) begin
            rd_mux[7:0] = prio_q[dp_addr_q[4:2]];
        end else begin
            unique case (dp_addr_q)
                vpic_pkg::ADDR_SENS_BIT_LO: rd_mux[7:0] = sens_lo_q;
                vpic_pkg::ADDR_SENS_BIT_HI: rd_mux[7:0] = sens_hi_q;
                vpic_pkg::ADDR_SENS_PORT_LO: rd_mux[7:0] = sens_port_q;
                vpic_pkg::ADDR_SENS_PORT_HI: rd_mux[3:0] = sens_port_hi_q;
                vpic_pkg::ADDR_PEND_BITS: rd_mux[7:0] = pend_bits_q;
                vpic_pkg::ADDR_PEND_GROUPS: rd_mux[2:0] = pend_grp_q;
                vpic_pkg::ADDR_GROUP_SEL: rd_mux[5:0] = group_sel_q;
                vpic_pkg::ADDR_FLAGS: rd_mux[7:0] = flags_q;
                vpic_pkg::ADDR_STATUS: rd_mux[7:0] = {1'b0, irq_vector_q, irq_valid_q, nested_mode};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // Priority fields, pair n mod 4 of register n/4 belongs to vector n
    always_ff @(posedge mclk) begin
        if (reset) begin
            for (int r = 0; r < vpic_pkg::NUM_PRIO_REGS; r++) begin
                prio_q[r] <= vpic_pkg::PRIO_RESET;
            end
        end else if (wr_en && dp_addr_q[1:0] == 2'b00 && dp_addr_q[7:2] <= vpic_pkg::PRIO_IDX_LAST[5:0]) begin
            prio_q[dp_addr_q[4:2]] <= prio_merge(prio_q[dp_addr_q[4:2]], hwdata[7:0]);
            if (dp_addr_q[4:2] == vpic_pkg::PRIO_IDX_LAST[2:0]) begin
                prio_q[dp_addr_q[4:2]] <= prio_merge(prio_q[dp_addr_q[4:2]], hwdata[7:0])
                    | vpic_pkg::PRIO_LAST_FORCED;
            end
        end
    end

    always_comb begin
        for (int v = 0; v < vpic_pkg::NUM_VEC; v++) begin
            vec_code[v] = prio_q[v / 4][2 * (v % 4) +: 2];
        end
    end

    // Nested as soon as any vector is below level 3
    always_comb begin
        nested_mode = 1'b0;
        for (int v = 0; v < vpic_pkg::NUM_VEC; v++) begin
            if (vec_code[v] != vpic_pkg::LVL3) begin
                nested_mode = 1'b1;
            end
        end
    end

    // Sensitivity and group routing
    always_ff @(posedge mclk) begin
        if (reset) begin
            sens_lo_q <= vpic_pkg::SENS_RESET;
            sens_hi_q <= vpic_pkg::SENS_RESET;
            sens_port_q <= vpic_pkg::SENS_RESET;
            sens_port_hi_q <= vpic_pkg::SENS_HI_RESET;
        end else if (wr_en && cur_code == vpic_pkg::LVL3) begin
            if (dp_addr_q == vpic_pkg::ADDR_SENS_BIT_LO) begin
                sens_lo_q <= hwdata[7:0];
            end
            if (dp_addr_q == vpic_pkg::ADDR_SENS_BIT_HI) begin
                sens_hi_q <= hwdata[7:0];
            end
            if (dp_addr_q == vpic_pkg::ADDR_SENS_PORT_LO) begin
                sens_port_q <= hwdata[7:0];
            end
            if (dp_addr_q == vpic_pkg::ADDR_SENS_PORT_HI) begin
                sens_port_hi_q <= hwdata[3:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            group_sel_q <= vpic_pkg::GROUP_SEL_RESET;
        end else if (wr_en && dp_addr_q == vpic_pkg::ADDR_GROUP_SEL) begin
            group_sel_q <= hwdata[5:0];
        end
    end

    // Pin synchroniser; resets to idle-high, no false edge
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_meta_q <= 64'hFFFF_FFFF_FFFF_FFFF;
            pin_sync_q <= 64'hFFFF_FFFF_FFFF_FFFF;
            pin_prev_q <= 64'hFFFF_FFFF_FFFF_FFFF;
        end else begin
            pin_meta_q <= pins.level;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    // Pin events folded onto bit and port-group vectors
    always_comb begin
        logic [1:0] grp_idx;
        logic in_grp;
        logic [1:0] psens;
        logic qual;
        logic ev;
        int idx;
        grp_idx = 2'd0;
        in_grp = 1'b0;
        psens = vpic_pkg::SENS_FALL_LOW;
        qual = 1'b0;
        ev = 1'b0;
        idx = 0;
        bit_event = 8'h00;
        grp_event = 3'h0;
        for (int p = 0; p < vpic_pkg::NUM_PORTS; p++) begin
            in_grp = 1'b0;
            grp_idx = 2'd0;
            psens = vpic_pkg::SENS_FALL_LOW;
            if (p == vpic_pkg::PORT_B) begin
                in_grp = group_sel_q[0] & ~group_sel_q[1];
                grp_idx = 2'd0;
                psens = sens_port_q[1:0];
            end else if (p == vpic_pkg::PORT_G) begin
                in_grp = group_sel_q[0] & group_sel_q[1];
                grp_idx = 2'd0;
                psens = sens_port_hi_q[1:0];
            end else if (p == vpic_pkg::PORT_D) begin
                in_grp = group_sel_q[2] & ~group_sel_q[3];
                grp_idx = 2'd1;
                psens = sens_port_q[3:2];
            end else if (p == vpic_pkg::PORT_H) begin
                in_grp = group_sel_q[2] & group_sel_q[3];
                grp_idx = 2'd1;
                psens = sens_port_hi_q[3:2];
            end else if (p == vpic_pkg::PORT_E) begin
                in_grp = group_sel_q[4] & ~group_sel_q[5];
                grp_idx = 2'd2;
                psens = sens_port_q[5:4];
            end else if (p == vpic_pkg::PORT_F) begin
                in_grp = group_sel_q[4] & group_sel_q[5];
                grp_idx = 2'd2;
                psens = sens_port_q[7:6];
            end
            for (int b = 0; b < 8; b++) begin
                idx = p * 8 + b;
                qual = pins.is_input[idx] & pins.irq_en[idx];
                if (in_grp) begin
                    ev = qual & pin_event(psens, pin_sync_q[idx], pin_prev_q[idx]);
                    grp_event[grp_idx] = grp_event[grp_idx] | ev;
                end else if (p <= vpic_pkg::PORT_E || (p == vpic_pkg::PORT_F && b == 0)) begin
                    if (b < 4) begin
                        ev = qual & pin_event(sens_lo_q[2*b +: 2], pin_sync_q[idx], pin_prev_q[idx]);
                    end else begin
                        ev = qual & pin_event(sens_hi_q[2*(b-4) +: 2], pin_sync_q[idx], pin_prev_q[idx]);
                    end
                    bit_event[b] = bit_event[b] | ev;
                end
            end
        end
    end

    // Pending flags: event sets, write of one clears, set wins
    always_ff @(posedge mclk) begin
        if (reset) begin
            pend_bits_q <= vpic_pkg::PEND_RESET;
        end else if (wr_en && dp_addr_q == vpic_pkg::ADDR_PEND_BITS) begin
            pend_bits_q <= (pend_bits_q & ~hwdata[7:0]) | bit_event;
        end else begin
            pend_bits_q <= pend_bits_q | bit_event;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            pend_grp_q <= vpic_pkg::PEND_GRP_RESET;
        end else if (wr_en && dp_addr_q == vpic_pkg::ADDR_PEND_GROUPS) begin
            pend_grp_q <= (pend_grp_q & ~hwdata[2:0]) | grp_event;
        end else begin
            pend_grp_q <= pend_grp_q | grp_event;
        end
    end

    always_comb begin
        vec_req = periph_irq;
        vec_req[vpic_pkg::VEC_BIT0 +: 8] = periph_irq[vpic_pkg::VEC_BIT0 +: 8] | pend_bits_q;
        vec_req[vpic_pkg::VEC_GROUP_A] = periph_irq[vpic_pkg::VEC_GROUP_A] | pend_grp_q[0];
        vec_req[vpic_pkg::VEC_GROUP_B] = periph_irq[vpic_pkg::VEC_GROUP_B] | pend_grp_q[1];
        vec_req[vpic_pkg::VEC_GROUP_C] = periph_irq[vpic_pkg::VEC_GROUP_C] | pend_grp_q[2];
    end

    // Arbitration: higher software level wins, lower vector index breaks ties
    always_comb begin
        win_found = 1'b0;
        win_vec = 5'h00;
        win_code = vpic_pkg::LVL0;
        for (int v = vpic_pkg::NUM_VEC - 1; v >= 0; v--) begin
            if (vec_req[v] && code_rank(vec_code[v]) > code_rank(cur_code)) begin
                if (!win_found || code_rank(vec_code[v]) >= code_rank(win_code)) begin
                    win_found = 1'b1;
                    win_vec = v[4:0];
                    win_code = vec_code[v];
                end
            end
        end
    end

    assign level_change = cpu_op.irq_ack | cpu_op.trap_instr | cpu_op.handler_return_instr
        | cpu_op.flags_pop_instr | cpu_op.disable_irq_instr | cpu_op.enable_irq_instr
        | cpu_op.halt_instr | cpu_op.wait_irq_instr | cpu_op.wait_event_instr;

    // Offer drops for a cycle after any level change so the winner is rebuilt
    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_valid_q <= 1'b0;
            irq_vector_q <= 5'h00;
            irq_code_q <= vpic_pkg::LVL3;
        end else begin
            irq_valid_q <= win_found & ~level_change;
            irq_vector_q <= win_vec;
            irq_code_q <= win_code;
        end
    end

    assign irq_valid = irq_valid_q;
    assign irq_vector = irq_vector_q;

    // Current level bits; no nesting depth tracking at all
    always_ff @(posedge mclk) begin
        if (reset) begin
            flags_q <= vpic_pkg::FLAGS_RESET;
        end else if (cpu_op.irq_ack && irq_valid_q) begin
            flags_q[vpic_pkg::FLAG_LVL_HI_POS] <= irq_code_q[1];
            flags_q[vpic_pkg::FLAG_LVL_LO_POS] <= irq_code_q[0];
        end else if (cpu_op.trap_instr) begin
            flags_q[vpic_pkg::FLAG_LVL_HI_POS] <= vpic_pkg::LVL3[1];
            flags_q[vpic_pkg::FLAG_LVL_LO_POS] <= vpic_pkg::LVL3[0];
        end else if (cpu_op.handler_return_instr || cpu_op.flags_pop_instr) begin
            flags_q <= cpu_op.pop_data;
        end else if (cpu_op.disable_irq_instr) begin
            flags_q[vpic_pkg::FLAG_LVL_HI_POS] <= vpic_pkg::LVL3[1];
            flags_q[vpic_pkg::FLAG_LVL_LO_POS] <= vpic_pkg::LVL3[0];
        end else if (cpu_op.enable_irq_instr) begin
            flags_q[vpic_pkg::FLAG_LVL_HI_POS] <= vpic_pkg::LVL0[1];
            flags_q[vpic_pkg::FLAG_LVL_LO_POS] <= vpic_pkg::LVL0[0];
        end else if (cpu_op.halt_instr || cpu_op.wait_irq_instr || cpu_op.wait_event_instr) begin
            flags_q[vpic_pkg::FLAG_LVL_HI_POS] <= vpic_pkg::LVL0[1];
            flags_q[vpic_pkg::FLAG_LVL_LO_POS] <= vpic_pkg::LVL0[0];
        end
    end

    assign condition_code_flags = flags_q;
    assign branch_if_masked = (cur_code == vpic_pkg::LVL3);
    assign branch_if_unmasked = (cur_code != vpic_pkg::LVL3);
endmodule

// ===== verification/vpic_cpu_model.sv
`timescale 1ns/1ps
module vpic_cpu_model (
    input wire logic mclk,
    input wire logic irq_valid,
    input wire logic [7:0] condition_code_flags,
    output vpic_pkg::vpic_cpu_op_type cpu_op
);
    logic [7:0] saved_flags[$];

    initial cpu_op = '0;

    task automatic issue(input vpic_pkg::vpic_cpu_op_type op);
        @(posedge mclk);
        cpu_op <= op;
        @(posedge mclk);
        cpu_op <= '0;
    endtask

    // Acknowledge after some idle cycles, stacking the flags seen at the ack edge
    task automatic take_irq(input int slow);
        repeat (slow) @(posedge mclk);
        @(posedge mclk);
        cpu_op.irq_ack <= 1'h1;
        @(posedge mclk);
        saved_flags.push_back(condition_code_flags);
        cpu_op.irq_ack <= 1'h0;
    endtask

    task automatic leave_handler();
        vpic_pkg::vpic_cpu_op_type op;
        op = '0;
        op.handler_return_instr = 1'h1;
        op.pop_data = saved_flags.pop_back();
        issue(op);
    endtask
endmodule

// ===== verification/vpic_ctrl_monitor.sv
`timescale 1ns/1ps
module vpic_ctrl_monitor (
    input wire logic mclk,
    input wire logic reset,
    input wire vpic_pkg::vpic_cpu_op_type cpu_op,
    input wire logic irq_valid,
    input wire logic [7:0] condition_code_flags,
    input wire logic branch_if_masked,
    input wire logic branch_if_unmasked,
    input wire logic nested_mode
);
    logic [1:0] lvl;
    logic taken;
    logic over;

    assign lvl = {condition_code_flags[5], condition_code_flags[3]};
    assign taken = cpu_op.irq_ack && irq_valid;
    assign over = taken || cpu_op.trap_instr || cpu_op.handler_return_instr || cpu_op.flags_pop_instr;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_flags_reset_value: assert property (disable iff (1'h0) reset |=> condition_code_flags == 8'h28)
        else $error("flags not at reset value");
    a_enable_loads_low: assert property (cpu_op.enable_irq_instr && !over && !cpu_op.disable_irq_instr |=> lvl == 2'h2)
        else $error("enable did not load level 0");
    a_disable_loads_high: assert property (cpu_op.disable_irq_instr && !over |=> lvl == 2'h3)
        else $error("disable did not load level 3");
    a_trap_sets_high: assert property (cpu_op.trap_instr && !taken |=> lvl == 2'h3)
        else $error("trap did not load level 3");
    a_pop_restores_flags: assert property ((cpu_op.handler_return_instr || cpu_op.flags_pop_instr)
        && !taken && !cpu_op.trap_instr |=> condition_code_flags == $past(cpu_op.pop_data))
        else $error("popped flags not restored");
    a_ack_loads_field: assert property (taken |=> lvl != 2'h2 && !irq_valid)
        else $error("ack left level 0 or request standing");
    a_concurrent_at_three: assert property (taken && !nested_mode |=> lvl == 2'h3)
        else $error("concurrent handler not at level 3");
    a_branch_tracks_level: assert property (branch_if_masked == (lvl == 2'h3) && branch_if_unmasked == !branch_if_masked)
        else $error("branch outputs disagree with level");
    a_idle_keeps_level: assert property (cpu_op[16:8] == 9'h000 |=> $stable(condition_code_flags))
        else $error("flags changed without an instruction");
endmodule

bind vpic_ctrl vpic_ctrl_monitor vpic_ctrl_monitor_i (.mclk(mclk), .reset(reset), .cpu_op(cpu_op),
    .irq_valid(irq_valid), .condition_code_flags(condition_code_flags), .branch_if_masked(branch_if_masked),
    .branch_if_unmasked(branch_if_unmasked), .nested_mode(nested_mode));

// ===== verification/vpic_ctrl_tb.sv
`timescale 1ns/1ps
module vpic_ctrl_tb;
    logic mclk = 1'h0;
    logic reset = 1'h1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, irq_valid, branch_if_masked, branch_if_unmasked, nested_mode;
    logic [31:0] hrdata;
    logic [4:0] irq_vector;
    logic [7:0] condition_code_flags;
    logic [29:0] periph_irq = 30'h0;
    vpic_pkg::vpic_pins_type pins = '{level: 64'hFFFF_FFFF_FFFF_FFFF, is_input: 64'h0, irq_en: 64'h0};
    vpic_pkg::vpic_cpu_op_type cpu_op;
    int failures = 0;
    int total_checks = 0;

    always #5 mclk = ~mclk;

    vpic_ctrl vpic_ctrl_i (.mclk(mclk), .reset(reset), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .cpu_op(cpu_op), .periph_irq(periph_irq), .pins(pins), .irq_valid(irq_valid),
        .irq_vector(irq_vector), .condition_code_flags(condition_code_flags), .branch_if_masked(branch_if_masked),
        .branch_if_unmasked(branch_if_unmasked), .nested_mode(nested_mode));
    vpic_cpu_model vpic_cpu_model_i (.mclk(mclk), .irq_valid(irq_valid),
        .condition_code_flags(condition_code_flags), .cpu_op(cpu_op));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_ready();
        do @(posedge mclk); while (hreadyout !== 1'h1);
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] wd, output logic [31:0] rd);
        @(posedge mclk);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] unused;
        bus(a, 1'h1, d, unused);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] got;
        bus(a, 1'h0, 8'h00, got);
        check(got, exp);
        check(hresp, 1'h0);
    endtask

    task automatic lvl_is(input logic [7:0] exp);
        @(posedge mclk);
        check(condition_code_flags & 8'h28, exp);
    endtask

    task automatic do_op(input int b, input logic [7:0] lvl);
        vpic_pkg::vpic_cpu_op_type o;
        o = '0;
        o.enable_irq_instr = b == 0;
        o.disable_irq_instr = b == 1;
        o.halt_instr = b == 2;
        o.wait_irq_instr = b == 3;
        o.wait_event_instr = b == 4;
        o.trap_instr = b == 5;
        vpic_cpu_model_i.issue(o);
        lvl_is(lvl);
    endtask

    // Request line drops for a cycle after any instruction, so let it recompute
    task automatic expect_irq(input logic [4:0] v);
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 20 && irq_valid !== 1'h1; i++) @(posedge mclk);
        check(irq_valid, 1'h1);
        check(irq_vector, v);
    endtask

    task automatic no_irq();
        repeat (4) @(posedge mclk);
        check(irq_valid, 1'h0);
    endtask

    task automatic t_reset();
        for (int i = 0; i < 7; i++) rd_chk(8'(i * 4), 32'h0000_00FF);
        rd_chk(8'h1C, 32'h0000_00FF);
        rd_chk(8'h3C, 32'h0000_0028);
        rd_chk(8'h80, 32'h0000_0000);
        check(branch_if_masked, 1'h1);
    endtask

    task automatic t_prio();
        wr(8'h04, 8'hCF);
        wr(8'h04, 8'h64);
        rd_chk(8'h04, 32'h0000_0044);
        check(nested_mode, 1'h1);
        wr(8'h1C, 8'h00);
        rd_chk(8'h1C, 32'h0000_00F0);
        wr(8'h04, 8'hFF);
        wr(8'h1C, 8'hFF);
        rd_chk(8'h1C, 32'h0000_00FF);
        check(nested_mode, 1'h0);
    endtask

    task automatic t_concurrent();
        do_op(0, 8'h20);
        periph_irq <= 30'h0000_000A;
        expect_irq(5'h01);
        vpic_cpu_model_i.take_irq(0);
        lvl_is(8'h28);
        periph_irq <= 30'h0000_0008;
        no_irq();
        vpic_cpu_model_i.leave_handler();
        lvl_is(8'h20);
        expect_irq(5'h03);
        vpic_cpu_model_i.take_irq(3);
        periph_irq <= 30'h0;
        vpic_cpu_model_i.leave_handler();
    endtask

    task automatic t_nested();
        wr(8'h00, 8'hC7);
        periph_irq <= 30'h0000_0006;
        expect_irq(5'h02);
        vpic_cpu_model_i.take_irq(0);
        lvl_is(8'h00);
        no_irq();
        periph_irq <= 30'h0000_0007;
        expect_irq(5'h00);
        vpic_cpu_model_i.take_irq(0);
        lvl_is(8'h28);
        periph_irq <= 30'h0000_0006;
        vpic_cpu_model_i.leave_handler();
        lvl_is(8'h00);
        wr(8'h00, 8'hF7);
        expect_irq(5'h02);
        vpic_cpu_model_i.take_irq(0);
        periph_irq <= 30'h0;
        vpic_cpu_model_i.leave_handler();
        vpic_cpu_model_i.leave_handler();
        lvl_is(8'h20);
        wr(8'h00, 8'hFF);
    endtask

    task automatic t_ops();
        int op_of[8] = '{0, 1, 2, 1, 3, 1, 4, 5};
        logic [7:0] lvl_of[8] = '{8'h20, 8'h28, 8'h20, 8'h28, 8'h20, 8'h28, 8'h20, 8'h28};
        vpic_pkg::vpic_cpu_op_type o;
        o = '0;
        o.flags_pop_instr = 1'h1;
        o.pop_data = 8'h08;
        vpic_cpu_model_i.issue(o);
        lvl_is(8'h08);
        check(branch_if_unmasked, 1'h1);
        for (int i = 0; i < 8; i++) do_op(op_of[i], lvl_of[i]);
    endtask

    task automatic pin_pulse(input int p);
        pins.level[p] <= 1'h0;
        repeat (6) @(posedge mclk);
        pins.level[p] <= 1'h1;
        repeat (6) @(posedge mclk);
    endtask

    task automatic t_pins();
        wr(8'h20, 8'h01);
        rd_chk(8'h20, 32'h0000_0001);
        pins.is_input[0] <= 1'h1;
        pin_pulse(0);
        rd_chk(8'h30, 32'h0000_0000);
        pins.is_input[8] <= 1'h1;
        pins.irq_en[8] <= 1'h1;
        pin_pulse(8);
        rd_chk(8'h30, 32'h0000_0001);
        wr(8'h30, 8'h00);
        rd_chk(8'h30, 32'h0000_0001);
        wr(8'h30, 8'h01);
        rd_chk(8'h30, 32'h0000_0000);
        do_op(0, 8'h20);
        wr(8'h20, 8'h03);
        rd_chk(8'h20, 32'h0000_0001);
        pin_pulse(8);
        expect_irq(5'h08);
        vpic_cpu_model_i.take_irq(0);
        wr(8'h30, 8'h01);
        vpic_cpu_model_i.leave_handler();
        no_irq();
    endtask

    task automatic complete_run();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        reset <= 1'h0;
        t_reset();
        t_prio();
        t_concurrent();
        t_nested();
        t_ops();
        t_pins();
        complete_run();
    end

    initial begin
        repeat (4000) @(posedge mclk);
        failures++;
        complete_run();
    end
endmodule
